/* File: hdl/prot_pkg.sv */
package prot_pkg;

    // Category A event sources
    localparam int CAT_A_W = 3;
    localparam int A_DESAT = 0;
    localparam int A_OCP = 1;
    localparam int A_ENABLE = 2;

    // Category B event sources: UV on three supplies, OV on two, internal
    localparam int CAT_B_W = 6;
    localparam int B_UV_CC1 = 0;
    localparam int B_UV_CC2 = 1;
    localparam int B_UV_EE2 = 2;
    localparam int B_OV_EE2 = 3;
    localparam int B_OV_CC2 = 4;
    localparam int B_INTERNAL = 5;

    // Category C notifications
    localparam int CAT_C_W = 2;
    localparam int C_GATE = 0;
    localparam int C_OCP_SENSE = 1;

    // Category D self tests
    localparam int TEST_W = 5;
    localparam int T_DESAT = 0;
    localparam int T_OCP = 1;
    localparam int T_SUPPLY = 2;
    localparam int T_CLOCK = 3;
    localparam int T_DIO = 4;

    // Oscillator plausibility window, in reference ticks counted per window
    localparam int OSC_CNT_W = 8;
    localparam logic [OSC_CNT_W-1:0] OSC_WINDOW = 8'h40;
    localparam logic [OSC_CNT_W-1:0] OSC_MIN = 8'h1C;
    localparam logic [OSC_CNT_W-1:0] OSC_MAX = 8'h24;

    // Test duration in clock cycles
    localparam logic [7:0] TEST_CYCLES = 8'h10;

    // SPI check register reset value
    localparam logic [15:0] CHECK_RESET = 16'h0000;

    typedef enum logic [3:0] {
        ST_INIT = 4'b0001,
        ST_ACTIVE = 4'b0010,
        ST_DIS_FAST = 4'b0100,
        ST_DIS_SLOW = 4'b1000
    } op_state_e;

    typedef struct packed {
        logic [CAT_A_W-1:0] cat_a;
        logic [CAT_B_W-1:0] cat_b;
        logic [CAT_C_W-1:0] cat_c;
    } events_s;

    typedef struct packed {
        logic start;
        logic [TEST_W-1:0] sel;
    } test_req_s;

    typedef struct packed {
        logic busy;
        logic done;
        logic [TEST_W-1:0] pass;
        logic [TEST_W-1:0] fail;
    } test_stat_s;

endpackage

/* File: hdl/self_test.sv */
module self_test
    import prot_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input test_req_s i_req,
    input wire logic i_idle,
    input wire logic i_desat_cmp,
    input wire logic i_ocp_cmp,
    input wire logic i_supply_cmp,
    input wire logic i_osc_tick,
    input wire logic i_dio_loop,
    output logic o_inject,
    output test_stat_s o_stat
);

    logic [TEST_W-1:0] sel;
    logic [TEST_W-1:0] next_sel;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [OSC_CNT_W-1:0] ticks;
    logic [OSC_CNT_W-1:0] next_ticks;
    logic seen;
    logic next_seen;
    test_stat_s next_stat;
    logic next_inject;

    function automatic logic test_ok(input logic [TEST_W-1:0] s, input logic hit,
                                     input logic [OSC_CNT_W-1:0] t);
        if (s[T_CLOCK]) begin
            test_ok = (t >= OSC_MIN) && (t <= OSC_MAX);
        end else begin
            test_ok = hit;
        end
    endfunction

    always_comb begin
        next_sel = sel;
        next_cnt = cnt;
        next_ticks = ticks;
        next_seen = seen;
        next_stat = o_stat;
        next_inject = 1'b0;
        next_stat.done = 1'b0;
        if (!o_stat.busy) begin
            // Refused while running: the intrusive stimulus would upset switching
            if (i_req.start && i_idle && (i_req.sel != '0)) begin
                next_sel = i_req.sel;
                next_cnt = '0;
                next_ticks = '0;
                next_seen = 1'b0;
                next_stat.busy = 1'b1;
                next_stat.pass = '0;
                next_stat.fail = '0;
            end
        end else begin
            next_cnt = cnt + 8'h01;
            next_inject = ~sel[T_CLOCK];
            if (i_osc_tick && ticks != OSC_WINDOW) begin
                next_ticks = ticks + 8'h01;
            end
            if ((sel[T_DESAT] && i_desat_cmp)
                || (sel[T_OCP] && i_ocp_cmp)
                || (sel[T_SUPPLY] && i_supply_cmp)
                || (sel[T_DIO] && i_dio_loop)) begin
                next_seen = 1'b1;
            end
            // The clock check needs a full reference window to reach the tick band
            if (cnt == (sel[T_CLOCK] ? OSC_WINDOW : TEST_CYCLES)) begin
                next_stat.busy = 1'b0;
                next_stat.done = 1'b1;
                next_inject = 1'b0;
                if (test_ok(sel, seen, ticks)) begin
                    next_stat.pass = sel;
                end else begin
                    next_stat.fail = sel;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel <= '0;
            cnt <= '0;
            ticks <= '0;
            seen <= 1'b0;
            o_inject <= 1'b0;
            o_stat <= '0;
        end else begin
            sel <= next_sel;
            cnt <= next_cnt;
            ticks <= next_ticks;
            seen <= next_seen;
            o_inject <= next_inject;
            o_stat <= next_stat;
        end
    end

endmodule

/* File: hdl/protection_category_reaction.sv */
module protection_category_reaction
    import prot_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_pwm,
    input wire logic i_enable,
    input wire logic i_desat_over,
    input wire logic i_blank_done,
    input wire logic i_ocp_over,
    input wire logic i_ocp_sense_over,
    input wire logic i_uv_cc1,
    input wire logic i_uv_cc2,
    input wire logic i_uv_ee2,
    input wire logic i_ov_ee2,
    input wire logic i_ov_cc2,
    input wire logic i_internal_fail,
    input wire logic i_gate_fault,
    input wire logic i_fast_reactivate,
    input wire logic i_reinit,
    input wire logic i_clear_errors,
    input test_req_s i_test_req,
    input wire logic i_osc_tick,
    input wire logic i_dio_loop,
    input wire logic i_check_we,
    input wire logic [15:0] i_check_wdata,
    output logic o_gate_on,
    output logic o_tristate,
    output logic o_safe_off,
    output logic o_fault_notify_primary,
    output logic o_fault_notify_b,
    output logic o_notify_c,
    output logic o_switch_state,
    output logic o_desat_error_flag,
    output events_s o_errors,
    output op_state_e o_state,
    output logic o_inject,
    output test_stat_s o_test_stat,
    output logic [15:0] o_spi_check_register
);

    events_s ev;
    events_s next_errors;
    op_state_e next_state;
    logic next_gate_on;
    logic next_tristate;
    logic next_safe_off;
    logic next_notify_a;
    logic next_notify_b;
    logic next_notify_c;
    logic next_desat_flag;
    logic [15:0] next_check;
    logic any_a;
    logic any_b;
    logic idle;

    // Desat and overcurrent share one qualifier: command on, stage on, blanking over
    function automatic logic trip_armed(input logic cmd, input logic on, input logic blanked,
                                        input logic cmp);
        trip_armed = cmd && on && blanked && cmp;
    endfunction

    // Outside a self test, a restart is refused while any supply or internal fault is still present
    function automatic logic can_restart(input logic req, input logic en, input logic b_live);
        can_restart = req && en && !b_live;
    endfunction

    // Desat and overcurrent comparators only count while the stage is on and blanking is over; the sense comparator only needs the stage on
    always_comb begin
        ev = '0;
        ev.cat_a[A_DESAT] = trip_armed(i_pwm, o_gate_on, i_blank_done, i_desat_over);
        ev.cat_a[A_OCP] = trip_armed(i_pwm, o_gate_on, i_blank_done, i_ocp_over);
        ev.cat_a[A_ENABLE] = (o_state == ST_ACTIVE) && !i_enable;
        ev.cat_b[B_UV_CC1] = i_uv_cc1;
        ev.cat_b[B_UV_CC2] = i_uv_cc2;
        ev.cat_b[B_UV_EE2] = i_uv_ee2;
        ev.cat_b[B_OV_EE2] = i_ov_ee2;
        ev.cat_b[B_OV_CC2] = i_ov_cc2;
        ev.cat_b[B_INTERNAL] = i_internal_fail;
        ev.cat_c[C_GATE] = i_gate_fault && o_gate_on != i_pwm;
        ev.cat_c[C_OCP_SENSE] = i_ocp_sense_over && o_gate_on;
    end

    // Self tests stimulate the comparators, so they are masked out of the event path
    assign any_a = (|ev.cat_a) && !o_test_stat.busy;
    assign any_b = (|ev.cat_b) && !o_test_stat.busy;
    assign idle = (o_state != ST_ACTIVE) && !i_pwm;

    always_comb begin
        next_state = o_state;
        case (o_state)
            ST_INIT: begin
                if (can_restart(i_fast_reactivate, i_enable, any_b)) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (any_b) begin
                    next_state = ST_DIS_SLOW;
                end else if (any_a) begin
                    next_state = ST_DIS_FAST;
                end
            end
            ST_DIS_FAST: begin
                if (any_b) begin
                    next_state = ST_DIS_SLOW;
                end else if (can_restart(i_fast_reactivate, i_enable, any_b)) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_DIS_SLOW: begin
                // Fast reactivation is not enough here
                if (can_restart(i_reinit, 1'b1, any_b)) begin
                    next_state = ST_INIT;
                end
            end
            default: begin
                next_state = ST_INIT;
            end
        endcase
    end

    always_comb begin
        next_errors = o_errors;
        next_desat_flag = o_desat_error_flag;
        if (i_clear_errors) begin
            next_errors = '0;
            next_desat_flag = 1'b0;
        end
        // Set beats clear in the same cycle
        next_errors = next_errors | (o_test_stat.busy ? '0 : ev);
        if (ev.cat_a[A_DESAT] && !o_test_stat.busy) begin
            next_desat_flag = 1'b1;
        end
        // Category C never reaches the state or the gate output
        next_notify_c = |next_errors.cat_c;
        next_gate_on = (next_state == ST_ACTIVE) && i_pwm && !any_a && !any_b;
        next_tristate = (next_state != ST_ACTIVE);
        next_safe_off = o_gate_on && (any_a || any_b);
        next_notify_a = (next_state == ST_DIS_FAST) || (|next_errors.cat_a);
        next_notify_b = (next_state == ST_DIS_SLOW);
    end

    // Plain store and echo; the host compares what it reads back with what it wrote
    always_comb begin
        next_check = o_spi_check_register;
        if (i_check_we) begin
            next_check = i_check_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_state <= ST_INIT;
        end else begin
            o_state <= next_state;
        end
    end

    // Sticky, so the host can still read the cause once the stage is back
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_errors <= '0;
            o_desat_error_flag <= 1'b0;
        end else begin
            o_errors <= next_errors;
            o_desat_error_flag <= next_desat_flag;
        end
    end

    // Pin outputs straight from flops so comparator glitches never reach the stage
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_gate_on <= 1'b0;
            o_tristate <= 1'b1;
            o_safe_off <= 1'b0;
            o_fault_notify_primary <= 1'b0;
            o_fault_notify_b <= 1'b0;
            o_notify_c <= 1'b0;
            o_switch_state <= 1'b0;
        end else begin
            o_gate_on <= next_gate_on;
            o_tristate <= next_tristate;
            o_safe_off <= next_safe_off;
            o_fault_notify_primary <= next_notify_a;
            o_fault_notify_b <= next_notify_b;
            o_notify_c <= next_notify_c;
            o_switch_state <= o_gate_on;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_spi_check_register <= CHECK_RESET;
        end else begin
            o_spi_check_register <= next_check;
        end
    end

    self_test u_self_test (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_req(i_test_req),
        .i_idle(idle),
        .i_desat_cmp(i_desat_over),
        .i_ocp_cmp(i_ocp_over),
        .i_supply_cmp(|ev.cat_b[B_OV_CC2:B_UV_CC1]),
        .i_osc_tick(i_osc_tick),
        .i_dio_loop(i_dio_loop),
        .o_inject(o_inject),
        .o_stat(o_test_stat)
    );

endmodule

/* File: bench/prot_reaction_sva.sv */
module prot_reaction_sva
    import prot_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_pwm,
    input wire logic i_enable,
    input wire logic i_desat_over,
    input wire logic i_blank_done,
    input wire logic i_ocp_over,
    input wire logic i_uv_cc1,
    input wire logic i_uv_cc2,
    input wire logic i_uv_ee2,
    input wire logic i_ov_ee2,
    input wire logic i_ov_cc2,
    input wire logic i_internal_fail,
    input wire logic i_gate_fault,
    input wire logic i_fast_reactivate,
    input wire logic i_reinit,
    input wire logic o_gate_on,
    input wire logic o_fault_notify_primary,
    input wire logic o_fault_notify_b,
    input wire logic o_notify_c,
    input wire logic o_switch_state,
    input wire logic o_desat_error_flag,
    input events_s o_errors,
    input op_state_e o_state,
    input test_stat_s o_test_stat,
    input test_req_s i_test_req
);
    logic b_in;
    logic calm;
    assign b_in = i_uv_cc1 | i_uv_cc2 | i_uv_ee2 | i_ov_ee2 | i_ov_cc2 | i_internal_fail;
    // Running with no self test in progress
    assign calm = !o_test_stat.busy && o_state == ST_ACTIVE;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    desat_trip_a: assert property (
        calm && !b_in && o_gate_on && i_blank_done && i_desat_over |=> o_state == ST_DIS_FAST
        && o_desat_error_flag && o_fault_notify_primary) else $error("desat trip missing");
    enable_loss_a: assert property (
        calm && !b_in && !i_enable |=> o_state == ST_DIS_FAST && o_errors.cat_a[A_ENABLE])
        else $error("enable loss missing");
    ocp_trip_a: assert property (
        calm && !b_in && o_gate_on && i_blank_done && i_ocp_over |=> o_errors.cat_a[A_OCP]
        && o_state == ST_DIS_FAST) else $error("ocp trip missing");
    supply_trip_a: assert property (
        calm && b_in |=> o_state == ST_DIS_SLOW && o_fault_notify_b) else $error("supply trip");
    internal_trip_a: assert property (
        calm && i_internal_fail |=> o_errors.cat_b[B_INTERNAL]) else $error("internal trip");
    slow_hold_a: assert property (
        o_state == ST_DIS_SLOW && !i_reinit |=> o_state == ST_DIS_SLOW) else $error("slow left");
    fast_hold_a: assert property (
        o_state == ST_DIS_FAST && !i_fast_reactivate |=> o_state != ST_ACTIVE)
        else $error("fast left");
    gate_note_a: assert property (
        calm && !b_in && i_enable && !i_desat_over && !i_ocp_over && i_gate_fault
        && o_gate_on != i_pwm |=> o_notify_c && o_state == ST_ACTIVE) else $error("gate note");
    switch_echo_a: assert property (
        o_switch_state == $past(o_gate_on)) else $error("switch state lag");
    test_len_a: assert property (
        $rose(o_test_stat.busy) && !$past(i_test_req.sel[T_CLOCK]) |-> ##[16:18] o_test_stat.done)
        else $error("test length");
    clock_len_a: assert property (
        $rose(o_test_stat.busy) && $past(i_test_req.sel[T_CLOCK]) |-> ##[64:66] o_test_stat.done)
        else $error("clock test length");
    no_test_run_a: assert property (
        calm |=> !o_test_stat.busy) else $error("test while running");
    cover property (o_state == ST_DIS_FAST);
    cover property (o_state == ST_DIS_SLOW);
    cover property (o_test_stat.done);
endmodule
bind protection_category_reaction prot_reaction_sva chk (.*);

/* File: bench/host_model.sv */
module host_model
    import prot_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_auto,
    input wire logic [TEST_W-1:0] i_test_sel,
    input wire logic i_pwm,
    input op_state_e i_state,
    input test_stat_s i_stat,
    output logic o_fast_reactivate,
    output logic o_reinit,
    output test_req_s o_test_req
);
    // Reacts only when told, so the bench can hold a disabled state
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fast_reactivate <= 1'b0;
            o_reinit <= 1'b0;
            o_test_req <= '0;
        end else begin
            o_reinit <= i_auto && i_state == ST_DIS_SLOW;
            o_fast_reactivate <= i_auto && i_state inside {ST_INIT, ST_DIS_FAST};
            o_test_req.start <= |i_test_sel && i_state != ST_ACTIVE && !i_pwm
                && !i_stat.busy && !o_test_req.start;
            o_test_req.sel <= i_test_sel;
        end
    end
endmodule

/* File: bench/protection_category_reaction_tb.sv */
module protection_category_reaction_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import prot_pkg::*;
    logic clk = 0, rst_n = 0, pwm = 0, en = 1, desat = 0, blank = 0, ocp = 0, ocps = 0;
    logic gf = 0, clr = 0, dio = 0, we = 0, auto = 0, tick = 0;
    logic [CAT_B_W-1:0] bsrc = '0;
    logic [TEST_W-1:0] tsel = '0;
    logic [15:0] wd = '0;
    logic gate_on, tri_st, safe_off, nfa, nfb, nc, sw, dflag, inj, fr, ri;
    logic [15:0] chk;
    events_s errs;
    op_state_e st;
    test_stat_s ts;
    test_req_s treq;
    int mismatches = 0, checks = 0, cyc = 0, mi = -1, i, k, m;
    logic q[$];
    always #10 clk = ~clk;
    protection_category_reaction uut (.i_clk(clk), .i_reset_n(rst_n), .i_pwm(pwm),
        .i_enable(en), .i_desat_over(desat), .i_blank_done(blank), .i_ocp_over(ocp),
        .i_ocp_sense_over(ocps), .i_uv_cc1(bsrc[B_UV_CC1]), .i_uv_cc2(bsrc[B_UV_CC2]),
        .i_uv_ee2(bsrc[B_UV_EE2]), .i_ov_ee2(bsrc[B_OV_EE2]), .i_ov_cc2(bsrc[B_OV_CC2]),
        .i_internal_fail(bsrc[B_INTERNAL]), .i_gate_fault(gf), .i_fast_reactivate(fr),
        .i_reinit(ri), .i_clear_errors(clr), .i_test_req(treq), .i_osc_tick(tick),
        .i_dio_loop(dio), .i_check_we(we), .i_check_wdata(wd), .o_gate_on(gate_on),
        .o_tristate(tri_st), .o_safe_off(safe_off), .o_fault_notify_primary(nfa),
        .o_fault_notify_b(nfb), .o_notify_c(nc), .o_switch_state(sw),
        .o_desat_error_flag(dflag), .o_errors(errs), .o_state(st), .o_inject(inj),
        .o_test_stat(ts), .o_spi_check_register(chk));
    host_model host (.i_clk(clk), .i_reset_n(rst_n), .i_auto(auto), .i_test_sel(tsel),
        .i_pwm(pwm), .i_state(st), .i_stat(ts), .o_fast_reactivate(fr), .o_reinit(ri),
        .o_test_req(treq));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            mismatches++;
            final_report();
        end
    end
    // Loopback of the injected stimulus onto the comparator under test
    always @(negedge clk) if (mi >= 0) begin
        desat = inj && mi == T_DESAT;
        ocp = inj && mi == T_OCP;
        ocps = ocp;
        bsrc[4:0] = {5{inj && mi == T_SUPPLY}};
        dio = inj && mi == T_DIO;
        // Half-rate tick lands inside the band; the last pass sticks it high
        tick = mi == T_CLOCK && (k == TEST_W || !tick);
    end
    task automatic activate;
        pwm = 0;
        auto = 1;
        for (int j = 0; j < 20 && st !== ST_ACTIVE; j++) @(negedge clk);
        check("act", st, ST_ACTIVE);
        auto = 0;
    endtask
    task automatic pulse_clear;
        clr = 1;
        @(negedge clk);
        clr = 0;
        @(negedge clk);
        check("clr", errs, 0);
    endtask
    initial begin
        void'($urandom(11547));
        repeat (4) @(negedge clk);
        check("rst st", st, ST_INIT);
        check("rst tri", tri_st, 1);
        check("rst chk", chk, CHECK_RESET);
        rst_n = 1;
        activate();
        for (i = 0; i < 40; i++) begin
            pwm = 1'($urandom);
            gf = 1'($urandom);
            q.push_back(pwm);
            @(negedge clk);
            check("gate", gate_on, q[$]);
            if (q.size() > 1) check("sw", sw, q[$-1]);
        end
        check("stay", st, ST_ACTIVE);
        pwm = 0;
        gf = 0;
        repeat (2) @(negedge clk);
        pulse_clear();
        pwm = 1;
        gf = 1;
        @(negedge clk);
        gf = 0;
        ocps = 1;
        @(negedge clk);
        ocps = 0;
        @(negedge clk);
        check("cat c", errs.cat_c, 2'b11);
        check("note c", nc, 1);
        check("still on", {st, tri_st, gate_on}, {ST_ACTIVE, 2'b01});
        pwm = 0;
        pulse_clear();
        for (k = 0; k < CAT_A_W; k++) begin
            pwm = 1;
            blank = 1;
            repeat (2) @(negedge clk);
            desat = k == A_DESAT;
            ocp = k == A_OCP;
            en = k != A_ENABLE;
            @(negedge clk);
            check("a st", st, ST_DIS_FAST);
            check("a out", {tri_st, gate_on, safe_off, nfa}, 4'b1011);
            check("a err", errs.cat_a, 3'b001 << k);
            check("a flag", dflag, k == A_DESAT);
            {desat, ocp, en, blank, pwm} = 5'b00100;
            repeat (3) @(negedge clk);
            check("a hold", st, ST_DIS_FAST);
            pulse_clear();
            activate();
        end
        for (k = 0; k < CAT_B_W; k++) begin
            pwm = 1;
            repeat (2) @(negedge clk);
            bsrc[k] = 1;
            @(negedge clk);
            check("b st", {st, tri_st, nfb}, {ST_DIS_SLOW, 2'b11});
            check("b err", errs.cat_b, 6'b000001 << k);
            pwm = 0;
            auto = 1;
            repeat (6) @(negedge clk);
            check("b refuse", st == ST_ACTIVE, 0);
            bsrc = '0;
            pulse_clear();
            activate();
        end
        en = 0;
        @(negedge clk);
        en = 1;
        blank = 1;
        for (k = 0; k <= TEST_W; k++) begin
            m = (k == TEST_W) ? T_CLOCK : k;
            tsel = 5'b00001 << m;
            for (i = 0; i < 10 && ts.busy !== 1'b1; i++) @(negedge clk);
            tsel = '0;
            mi = m;
            @(negedge clk);
            check("inj", inj, m != T_CLOCK);
            for (i = 0; i < 80 && ts.done !== 1'b1; i++) @(negedge clk);
            check("done", ts.done, 1);
            check("pass", ts.pass[m], k != TEST_W);
            check("fail", ts.fail[m], k == TEST_W);
            @(negedge clk);
            mi = -1;
            {desat, ocp, ocps, dio, tick, bsrc} = '0;
        end
        we = 1;
        for (k = 0; k < 4; k++) begin
            wd = 16'($urandom);
            @(negedge clk);
            check("chk", chk, wd);
        end
        we = 0;
        wd = ~wd;
        @(negedge clk);
        check("chk hold", chk, ~wd);
        final_report();
    end
endmodule
